/* logic/bmmc_top.sv */
// boot mode selection, boot select pins, timers, scan chain, bus float
`timescale 1ns/1ps

// Summary of operation
// - rom strap low: mode from link strap and sampled select pin
// - straps 0,1 and select 1: boot through the link port
// - straps 0,0 and select 1: boot loads from the host processor
// - straps 0,0 and select 0: no boot, run from external memory
// - only the current bus master drives the boot select output
// - select pin is driven only in eprom mode; otherwise it is an input
// - timer expired output high four cycles when an enabled count reaches one
// - one instruction per clock; clock runs steadily above minimum rate
// - scan chain enters at processor a and leaves at processor d
// - test clock is asynchronous and sampled by clk; its edges move only the scan logic
// - bus outputs float when suspend is asserted or module is slave
module bmmc_top
   import bmmc_pkg::*;
#(
   parameter int NPROC    = BMMC_NUM_PROC,
   parameter int TIMER_W  = BMMC_TIMER_W,
   parameter int SCAN_LEN = BMMC_SCAN_LEN
) (
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire logic               romBootStrapA,
   input  wire logic               linkBootStrapA,
   input  wire logic               bootMemorySelectAIn,
   output logic                    bootMemorySelectAOut,
   output logic                    bootMemorySelectAOe,
   input  wire logic               romBootStrapGroup,
   input  wire logic               linkBootStrapGroup,
   input  wire logic               bootMemorySelectGroupIn,
   output logic                    bootMemorySelectGroupOut,
   output logic                    bootMemorySelectGroupOe,
   input  wire logic               bootReadA,
   input  wire logic               bootReadGroup,
   input  wire logic               busMasterA,
   input  wire logic               busMasterGroup,
   input  wire logic               suspendBusFloat,
   output logic                    busDriveEn,
   output bmmc_boot_t              bootModeA,
   output bmmc_boot_t              bootModeGroup,
   output logic                    bootModeValid,
   output logic                    strapReserved,
   input  wire logic [NPROC-1:0]   timerEnable,
   input  wire logic [NPROC-1:0]   timerLoad,
   input  wire logic [TIMER_W-1:0] timerPeriod,
   output logic [NPROC-1:0]        timerExpiredOut,
   input  wire logic               testClock,
   input  wire logic               testReset_n,
   input  wire logic               testModeSelect,
   input  wire logic               testDataIn,
   output logic                    testDataOut
);

   // ***************************************************************
   // elaboration checks
   // ***************************************************************
   if (NPROC != 4) begin : g_badProc
      $error("processor count must be four");
   end
   if (TIMER_W < 2 || SCAN_LEN < 1) begin : g_badSize
      $error("timer width or scan length too small");
   end

   // ***************************************************************
   // strap sampling and boot mode latch
   // ***************************************************************
   bmmc_strap_t strapA;
   bmmc_strap_t strapGroup;
   logic        bootLatched;

   // no reset here on purpose: these flops must keep sampling the pins
   // while module reset is held, so the mode is ready at release
   always_ff @(posedge clk) begin
      if (!bootLatched) begin
         strapA     <= {romBootStrapA, linkBootStrapA, bootMemorySelectAIn};
         strapGroup <= {romBootStrapGroup, linkBootStrapGroup,
                        bootMemorySelectGroupIn};
      end
   end

   // the mode is taken once; later strap motion is not followed
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bootLatched   <= 1'b0;
         bootModeValid <= 1'b0;
         bootModeA     <= BMMC_BOOT_RST;
         bootModeGroup <= BMMC_BOOT_RST;
         strapReserved <= 1'b0;
      end else if (!bootLatched) begin
         bootLatched   <= 1'b1;
         bootModeValid <= 1'b1;
         bootModeA     <= bmmc_decode(strapA);
         bootModeGroup <= bmmc_decode(strapGroup);
         strapReserved <= (bmmc_decode(strapA) == BMMC_BOOT_RESV) ||
                          (bmmc_decode(strapGroup) == BMMC_BOOT_RESV);
      end
   end

   // ***************************************************************
   // boot select pins and bus float
   // ***************************************************************
   logic eepromA;
   logic eepromGroup;
   logic driveA;
   logic driveGroup;

   assign eepromA     = bootModeValid && (bootModeA == BMMC_BOOT_EPROM);
   assign eepromGroup = bootModeValid && (bootModeGroup == BMMC_BOOT_EPROM);
   assign driveA      = eepromA && busMasterA && !suspendBusFloat;
   assign driveGroup  = eepromGroup && busMasterGroup && !suspendBusFloat;

   // chip select is active low; outside eprom mode the pin stays an input
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bootMemorySelectAOut     <= 1'b1;
         bootMemorySelectAOe      <= 1'b0;
         bootMemorySelectGroupOut <= 1'b1;
         bootMemorySelectGroupOe  <= 1'b0;
      end else begin
         bootMemorySelectAOut     <= !(bootReadA && eepromA);
         bootMemorySelectAOe      <= driveA;
         bootMemorySelectGroupOut <= !(bootReadGroup && eepromGroup);
         bootMemorySelectGroupOe  <= driveGroup;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busDriveEn <= 1'b0;
      end else begin
         busDriveEn <= (busMasterA || busMasterGroup) &&
                       !suspendBusFloat;
      end
   end

   // ***************************************************************
   // per processor timers
   // ***************************************************************
   logic [NPROC-1:0] timerFire;

   for (genvar p = 0; p < NPROC; p++) begin : g_timer
      logic [TIMER_W-1:0] period;
      logic [TIMER_W-1:0] count;
      logic [2:0]         pulseLeft;

      // one decrement per clock, as the core runs one instruction a clock
      assign timerFire[p] = timerEnable[p] && !timerLoad[p] &&
                            (count == TIMER_W'(1));

      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            period <= '0;
            count  <= '0;
         end else if (timerLoad[p]) begin
            period <= timerPeriod;
            count  <= timerPeriod;
         end else if (timerEnable[p]) begin
            if (count <= TIMER_W'(1)) begin
               count <= period;
            end else begin
               count <= count - TIMER_W'(1);
            end
         end
      end

      // a new expiry inside a pulse restarts the four cycle count
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            pulseLeft          <= BMMC_PULSE_RST;
            timerExpiredOut[p] <= 1'b0;
         end else if (timerFire[p]) begin
            pulseLeft          <= BMMC_PULSE_LOAD;
            timerExpiredOut[p] <= 1'b1;
         end else if (pulseLeft != BMMC_PULSE_RST) begin
            pulseLeft          <= pulseLeft - 3'h1;
            timerExpiredOut[p] <= 1'b1;
         end else begin
            timerExpiredOut[p] <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // scan chain, processor a first, processor d last
   // ***************************************************************
   logic [2:0] tckSync;
   logic [1:0] trstSync;
   logic       tckRise;
   logic [NPROC*SCAN_LEN-1:0] scanChain;

   // test pins are sampled: the test clock has no fixed phase to clk
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tckSync  <= 3'h0;
         trstSync <= 2'h0;
      end else begin
         tckSync  <= {tckSync[1:0], testClock};
         trstSync <= {trstSync[0], testReset_n};
      end
   end

   assign tckRise = tckSync[1] && !tckSync[2];

   // test clock edges move only the scan cells, nothing else
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scanChain   <= '0;
         testDataOut <= 1'b0;
      end else if (!trstSync[1]) begin
         scanChain   <= '0;
         testDataOut <= 1'b0;
      end else if (tckRise && !testModeSelect) begin
         scanChain   <= {scanChain[NPROC*SCAN_LEN-2:0], testDataIn};
         testDataOut <= scanChain[NPROC*SCAN_LEN-1];
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   eprom_drive_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      driveA |=> bootMemorySelectAOe)
      else $error("boot select a not driven by master");

   select_input_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      (bootModeValid && bootModeA != BMMC_BOOT_EPROM)
         |=> !bootMemorySelectAOe)
      else $error("boot select a driven outside eprom mode");

   group_float_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      !busMasterGroup |=> !bootMemorySelectGroupOe)
      else $error("group boot select driven while slave");

   mode_decode_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      $rose(bootModeValid) |->
         bootModeA == bmmc_decode($past(strapA)))
      else $error("boot mode a decode wrong");

   group_hold_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      bootModeValid |=> bootModeValid && $stable(bootModeGroup))
      else $error("group boot mode changed after latch");

   expire_pulse_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      timerFire[0] |=> timerExpiredOut[0] [*4])
      else $error("timer expired pulse shorter than four");

   expire_end_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      (!timerFire[0] [*4]) |=> !timerExpiredOut[0])
      else $error("timer expired pulse too long");

   bus_float_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      (suspendBusFloat || !(busMasterA || busMasterGroup))
         |=> !busDriveEn && !bootMemorySelectAOe)
      else $error("bus driven while suspended or slave");

   scan_out_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      (trstSync[1] && tckRise && !testModeSelect) |=>
         testDataOut == $past(scanChain[NPROC*SCAN_LEN-1]))
      else $error("scan output not from last cell");

   scan_reset_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      !trstSync[1] |=> !testDataOut && scanChain == '0)
      else $error("test reset did not clear scan chain");

   group_drive_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      driveGroup |=> bootMemorySelectGroupOe)
      else $error("group boot select not driven by master");

   chip_select_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      (bootReadA && eepromA) |=> !bootMemorySelectAOut)
      else $error("boot select a not strobed in eprom read");

   select_idle_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      !eepromA |=> bootMemorySelectAOut)
      else $error("boot select a strobed outside eprom mode");

   group_decode_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      $rose(bootModeValid) |->
         bootModeGroup == bmmc_decode($past(strapGroup)))
      else $error("group boot mode decode wrong");

   mode_hold_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      bootModeValid |=> $stable(bootModeA))
      else $error("boot mode a changed after latch");

   bus_drive_a : assert property (
      @(posedge clk) disable iff (!arst_n)
      (busMasterA && !suspendBusFloat) |=> busDriveEn)
      else $error("bus not driven by master");

endmodule

/* logic/bmmc_pkg.sv */
// package for the boot mode and module control block
package bmmc_pkg;

   // ***************************************************************
   // sizes and timing
   // ***************************************************************
   localparam int          BMMC_NUM_PROC      = 4;
   localparam int          BMMC_TIMER_W       = 32;
   localparam int          BMMC_SCAN_LEN      = 8;
   localparam int          BMMC_EXPIRE_CYCLES = 4;
   localparam int          BMMC_CLK_PERIOD_NS = 10;
   localparam logic [2:0]  BMMC_PULSE_RST     = 3'h0;
   localparam logic [2:0]  BMMC_PULSE_LOAD    = 3'(BMMC_EXPIRE_CYCLES - 1);

   // ***************************************************************
   // strap carrier
   // ***************************************************************
   typedef struct packed {
      logic rom;
      logic link;
      logic sel;
   } bmmc_strap_t;

   localparam bmmc_strap_t BMMC_STRAP_RST = 3'h0;

   // ***************************************************************
   // boot modes, one hot
   // ***************************************************************
   typedef enum logic [4:0] {
      BMMC_BOOT_EPROM = 5'h01,
      BMMC_BOOT_HOST  = 5'h02,
      BMMC_BOOT_LINK  = 5'h04,
      BMMC_BOOT_NONE  = 5'h08,
      BMMC_BOOT_RESV  = 5'h10
   } bmmc_boot_t;

   localparam bmmc_boot_t BMMC_BOOT_RST = BMMC_BOOT_NONE;

   // strap decode, shared by both processor groups
   function automatic bmmc_boot_t bmmc_decode(input bmmc_strap_t s);
      bmmc_boot_t m;
      m = BMMC_BOOT_RESV;
      if (s.rom && !s.link) begin
         m = BMMC_BOOT_EPROM;
      end else if (!s.rom && s.link && s.sel) begin
         m = BMMC_BOOT_LINK;
      end else if (!s.rom && !s.link && s.sel) begin
         m = BMMC_BOOT_HOST;
      end else if (!s.rom && !s.link && !s.sel) begin
         m = BMMC_BOOT_NONE;
      end
      return m;
   endfunction

endpackage

/* bench/bmmc_board_model.sv */
// board side model: boot straps and the shared boot select wire
`timescale 1ns/1ps
module bmmc_board_model (
   input  wire logic arst_n,
   input  wire logic breakFixed,
   input  wire logic romSet,
   input  wire logic linkSet,
   input  wire logic selSet,
   input  wire logic selOut,
   input  wire logic selOe,
   output logic      romStrap,
   output logic      linkStrap,
   output logic      selPin
);
   logic selStrap;
   // straps follow a request only in reset or while breakFixed is high, as if hardwired
   // reserved levels appear only when a scenario asks for them
   always_latch begin
      if (!arst_n || breakFixed) begin
         romStrap  <= romSet;
         linkStrap <= linkSet;
         selStrap  <= selSet;
      end
   end
   // an undriven pin rests at the level strapped on the board
   assign selPin = selOe ? selOut : selStrap;
endmodule

/* bench/bmmc_top_test.sv */
// self-checking bench for boot mode and module control
`timescale 1ns/1ps
module bmmc_top_test;
   import bmmc_pkg::*;
   // ************************************************
   // signals
   // ************************************************
   logic        clk, arst_n, brk;
   logic [2:0]  setA, setG;
   logic        romA, linkA, pinA, outA, oeA;
   logic        romG, linkG, pinG, outG, oeG;
   logic        readA, readG, mastA, mastG, susp, driveEn;
   bmmc_boot_t  modeA, modeG;
   logic        valid, resv;
   logic [3:0]  tEn, tLoad, tExp;
   logic [31:0] tPeriod;
   logic        tck, trst_n, tms, tdi, tdo;
   int          mismatches, nCompared;

   bmmc_board_model brdA (.arst_n(arst_n), .breakFixed(brk),
      .romSet(setA[2]), .linkSet(setA[1]), .selSet(setA[0]),
      .selOut(outA), .selOe(oeA), .romStrap(romA), .linkStrap(linkA),
      .selPin(pinA));
   bmmc_board_model brdG (.arst_n(arst_n), .breakFixed(brk),
      .romSet(setG[2]), .linkSet(setG[1]), .selSet(setG[0]),
      .selOut(outG), .selOe(oeG), .romStrap(romG), .linkStrap(linkG),
      .selPin(pinG));
   bmmc_top dut (.clk(clk), .arst_n(arst_n), .romBootStrapA(romA),
      .linkBootStrapA(linkA), .bootMemorySelectAIn(pinA),
      .bootMemorySelectAOut(outA), .bootMemorySelectAOe(oeA),
      .romBootStrapGroup(romG), .linkBootStrapGroup(linkG),
      .bootMemorySelectGroupIn(pinG), .bootMemorySelectGroupOut(outG),
      .bootMemorySelectGroupOe(oeG), .bootReadA(readA),
      .bootReadGroup(readG), .busMasterA(mastA), .busMasterGroup(mastG),
      .suspendBusFloat(susp), .busDriveEn(driveEn), .bootModeA(modeA),
      .bootModeGroup(modeG), .bootModeValid(valid), .strapReserved(resv),
      .timerEnable(tEn), .timerLoad(tLoad), .timerPeriod(tPeriod),
      .timerExpiredOut(tExp), .testClock(tck), .testReset_n(trst_n),
      .testModeSelect(tms), .testDataIn(tdi), .testDataOut(tdo));

   // free running, never halted or retimed
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ************************************************
   // shared tasks
   // ************************************************
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic closeOut;
      $display("compared %0d, mismatches %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // straps are applied while reset is held, as a board would
   task automatic doReset(input logic [2:0] a, input logic [2:0] g);
      arst_n = 1'b0;
      setA = a;
      setG = g;
      cyc(6);
      arst_n = 1'b1;
      cyc(3);
   endtask
   // ************************************************
   // scenarios
   // ************************************************
   task automatic testModes;
      logic [2:0] combo [6];
      bmmc_boot_t want [6];
      int         k;
      combo = '{3'h5, 3'h1, 3'h3, 3'h0, 3'h2, 3'h6};
      want = '{BMMC_BOOT_EPROM, BMMC_BOOT_HOST, BMMC_BOOT_LINK,
               BMMC_BOOT_NONE, BMMC_BOOT_RESV, BMMC_BOOT_RESV};
      for (int i = 0; i < 6; i++) begin
         k = (i + 1) % 6;
         doReset(combo[i], combo[k]);
         check("modeA", 32'(modeA), 32'(want[i]));
         check("modeG", 32'(modeG), 32'(want[k]));
         check("valid", 32'(valid), 32'h1);
         check("resv", 32'(resv), 32'(i >= 3));
      end
      // a strap moved in operation must not alter the latched mode
      brk = 1'b1;
      setA = 3'h0;
      setG = 3'h0;
      cyc(3);
      check("modeA", 32'(modeA), 32'(BMMC_BOOT_RESV));
      check("modeG", 32'(modeG), 32'(BMMC_BOOT_EPROM));
      brk = 1'b0;
      $display("modes test done");
   endtask

   task automatic testSelect;
      doReset(3'h5, 3'h4);
      readA = 1'b1;
      mastA = 1'b1;
      cyc(1);
      check("pinA", 32'(pinA), 32'h0);
      check("oeA", 32'(oeA), 32'h1);
      check("oeG", 32'(oeG), 32'h0);
      check("outG", 32'(outG), 32'h1);
      check("drive", 32'(driveEn), 32'h1);
      readA = 1'b0;
      mastA = 1'b0;
      readG = 1'b1;
      mastG = 1'b1;
      cyc(1);
      check("oeA", 32'(oeA), 32'h0);
      check("pinG", 32'(pinG), 32'h0);
      check("outA", 32'(outA), 32'h1);
      susp = 1'b1;
      cyc(1);
      check("oeG", 32'(oeG), 32'h0);
      check("drive", 32'(driveEn), 32'h0);
      susp = 1'b0;
      mastG = 1'b0;
      cyc(1);
      check("drive", 32'(driveEn), 32'h0);
      doReset(3'h1, 3'h3);
      readA = 1'b1;
      mastA = 1'b1;
      mastG = 1'b1;
      cyc(2);
      check("oeA", 32'(oeA), 32'h0);
      check("oeG", 32'(oeG), 32'h0);
      check("outA", 32'(outA), 32'h1);
      readA = 1'b0;
      readG = 1'b0;
      mastA = 1'b0;
      mastG = 1'b0;
      $display("select test done");
   endtask

   task automatic testTimer;
      logic [3:0] m;
      tPeriod = 32'h3;
      for (int p = 0; p < 4; p++) begin
         m = 4'(1 << p);
         tLoad = m;
         cyc(1);
         tLoad = 4'h0;
         tEn = m;
         cyc(2);
         check("texp", 32'(tExp), 32'h0);
         cyc(1);
         tEn = 4'h0;
         for (int j = 0; j < 5; j++) begin
            check("texp", 32'(tExp), 32'((j < 4) ? m : 4'h0));
            cyc(1);
         end
      end
      $display("timer test done");
   endtask

   task automatic testScan;
      logic [39:0] d;
      d = 40'h9C5A3E61B7;
      // test reset pulsed low once after power up
      trst_n = 1'b0;
      cyc(4);
      check("tdo", 32'(tdo), 32'h0);
      trst_n = 1'b1;
      cyc(4);
      for (int j = 0; j < 40; j++) begin
         tdi = d[j];
         tck = 1'b0;
         cyc(4);
         tck = 1'b1;
         cyc(4);
         check("tdo", 32'(tdo), 32'((j >= 32) ? d[j-32] : 1'b0));
      end
      tck = 1'b0;
      cyc(4);
      // with mode select high a test clock edge must not shift
      tms = 1'b1;
      tck = 1'b1;
      cyc(4);
      tms = 1'b0;
      tck = 1'b0;
      cyc(4);
      tck = 1'b1;
      cyc(4);
      check("tdo", 32'(tdo), 32'(d[8]));
      tck = 1'b0;
      cyc(4);
      $display("scan test done");
   endtask

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      $display("watchdog expired");
      closeOut();
   end

   initial begin
      {arst_n, brk, readA, readG, mastA, mastG, susp} = 7'h0;
      {setA, setG, tEn, tLoad, tPeriod} = '0;
      {tck, trst_n, tms, tdi} = 4'h0;
      mismatches = 0;
      nCompared = 0;
      @(negedge clk);
      testModes();
      testSelect();
      testTimer();
      testScan();
      closeOut();
   end
endmodule
